// [design/srx_alu.sv]
// Combinational result and flag logic for the datapath operations
`timescale 1ns/1ps
module srx_alu
    import srx_pkg::*;
(
    // Operation
    input  wire logic [2:0] op,
    // Operands
    input  wire logic [7:0] acc,
    input  wire logic [7:0] fval,
    input  wire logic [7:0] lit,
    input  wire logic       carry_in,
    // Result and flags
    output logic      [7:0] res,
    output logic            c_out,
    output logic            dc_out,
    output logic            upd_c,
    output logic            upd_dc,
    output logic            upd_z
);
    logic [7:0] sub_a;
    logic [8:0] full_sum;
    logic [4:0] nib_sum;

    // Subtraction as a + ~w + 1, so carry out means no borrow
    assign sub_a    = (op == SRX_OP_LIT_SUB) ? lit : fval;
    assign full_sum = {1'b0, sub_a} + {1'b0, ~acc} + 9'h001;
    assign nib_sum  = {1'b0, sub_a[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;

    always_comb
    begin
        res    = acc;
        c_out  = carry_in;
        dc_out = 1'b0;
        upd_c  = 1'b0;
        upd_dc = 1'b0;
        upd_z  = 1'b0;
        case (op)
            SRX_OP_LIT_SUB, SRX_OP_FILE_SUB:
            begin
                res    = full_sum[7:0];
                c_out  = full_sum[8];
                dc_out = nib_sum[4];
                upd_c  = 1'b1;
                upd_dc = 1'b1;
                upd_z  = 1'b1;
            end
            SRX_OP_ROT_R:
            begin
                res   = {carry_in, fval[7:1]};
                c_out = fval[0];
                upd_c = 1'b1;
            end
            SRX_OP_SWAP: res = {fval[3:0], fval[7:4]};
            SRX_OP_XOR_LIT:
            begin
                res   = acc ^ lit;
                upd_z = 1'b1;
            end
            SRX_OP_XOR_FILE:
            begin
                res   = acc ^ fval;
                upd_z = 1'b1;
            end
            default: res = acc;
        endcase
    end
endmodule

// [design/srx_exec.sv]
// Datapath for subtract, rotate, swap, xor and sleep, with its APB register slave
//
// Behaviour
// - Literal minus accumulator computes k minus W, writes W and updates carry, nibble carry and zero.
// - Rotate right shifts the register right, old carry into bit 7, old bit 0 into carry, no other flag.
// - Rotate right writes the accumulator when the target bit is 0 and the file register when 1.
// - File minus accumulator subtracts W from file register 0 to 127 and updates carry, nibble carry, zero.
// - File minus accumulator stores to the accumulator when the target bit is 0, else to the file register.
// - Sleep clears the watchdog counter and its prescaler to zero.
// - Sleep clears the active-low power-down bit, sets the active-low expiry bit and the sleep bit, and leaves carry, nibble carry and zero alone.
// - After sleep the block halts its oscillator and executes nothing more until woken.
// - Nibble exchange swaps bits 3:0 and 7:4 and leaves every flag alone.
// - Nibble exchange writes the accumulator when the target bit is 0 and the file register when 1.
// - Accumulator xor literal writes the accumulator and updates only the zero flag.
// - Accumulator xor file updates only zero and goes to the accumulator on 0, else to the register.
`timescale 1ns/1ps
module srx_exec
    import srx_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Wake and clock control
    input  wire logic        wake_pin,
    output logic             osc_run
);
    srx_state_type state_q;
    srx_state_type state_d;
    logic [7:0]  acc_q;
    logic        carry_q;
    logic        dc_q;
    logic        zero_q;
    logic        pd_q;
    logic        to_q;
    logic [7:0]  wdog_q;
    logic [7:0]  presc_q;
    logic [31:0] prdata_q;
    logic [31:0] last_cmd_q;
    logic        wake_s1_q;
    logic        wake_s2_q;

    // Bus decode
    logic        setup_rd;
    logic        acc_wr;
    logic        sel_exec;
    logic        sel_acc;
    logic        sel_status;
    logic        sel_wdog;
    logic        sel_file;
    logic        addr_hit;
    logic        asleep;
    logic [2:0]  cmd_op;
    logic        cmd_dest;
    logic [6:0]  cmd_idx;
    logic [7:0]  cmd_lit;
    logic        op_ok;
    logic        exec_go;
    logic        is_lit_op;
    logic        to_file;
    logic [7:0]  fval;
    logic [7:0]  apb_fval;
    logic [7:0]  alu_res;
    logic        alu_c;
    logic        alu_dc;
    logic        upd_c;
    logic        upd_dc;
    logic        upd_z;
    logic        rf_we;
    logic [6:0]  rf_waddr;
    logic [7:0]  rf_wdata;
    logic [31:0] status_word;
    logic [31:0] rd_mux;

    assign setup_rd   = psel & ~penable & ~pwrite;
    assign acc_wr     = psel & penable & pwrite;
    assign sel_exec   = paddr == SRX_EXEC_OFS;
    assign sel_acc    = paddr == SRX_ACC_OFS;
    assign sel_status = paddr == SRX_STATUS_OFS;
    assign sel_wdog   = paddr == SRX_WDOG_OFS;
    assign sel_file   = (paddr[11:9] == SRX_FILE_SEL) & (paddr[1:0] == 2'h0);
    assign addr_hit   = sel_exec | sel_acc | sel_status | sel_wdog | sel_file;
    assign asleep     = state_q == SRX_ASLEEP;

    assign cmd_op    = pwdata[SRX_EXEC_OP_LSB +: 3];
    assign cmd_dest  = pwdata[SRX_EXEC_DEST];
    assign cmd_idx   = pwdata[SRX_EXEC_IDX_LSB +: 7];
    assign cmd_lit   = pwdata[SRX_EXEC_LIT_LSB +: 8];
    assign op_ok     = cmd_op != SRX_OP_NONE;
    assign exec_go   = acc_wr & sel_exec & op_ok & ~asleep;
    assign is_lit_op = (cmd_op == SRX_OP_LIT_SUB) | (cmd_op == SRX_OP_XOR_LIT);

    assign to_file   = cmd_dest & ~is_lit_op & (cmd_op != SRX_OP_SLEEP);

    // Zero-wait access; a refused command or unmapped address answers with an error
    assign pready  = 1'b1;
    assign pslverr = psel & penable & (~addr_hit | (pwrite & sel_exec & (~op_ok | asleep)));
    assign prdata  = prdata_q;
    assign osc_run = ~asleep;

    // Exec write wins the port; both cannot occur in one access
    assign rf_we    = (exec_go & to_file) | (acc_wr & sel_file);
    assign rf_waddr = exec_go ? cmd_idx : paddr[8:2];
    assign rf_wdata = exec_go ? alu_res : pwdata[7:0];

    srx_regfile u_regfile
    (
        .clk     (pclk),
        .we      (rf_we),
        .waddr   (rf_waddr),
        .wdata   (rf_wdata),
        .raddr_a (cmd_idx),
        .rdata_a (fval),
        .raddr_b (paddr[8:2]),
        .rdata_b (apb_fval)
    );

    srx_alu u_alu
    (
        .op       (cmd_op),
        .acc      (acc_q),
        .fval     (fval),
        .lit      (cmd_lit),
        .carry_in (carry_q),
        .res      (alu_res),
        .c_out    (alu_c),
        .dc_out   (alu_dc),
        .upd_c    (upd_c),
        .upd_dc   (upd_dc),
        .upd_z    (upd_z)
    );

    assign status_word = {26'h0, asleep, to_q, pd_q, zero_q, dc_q, carry_q};
    assign rd_mux = sel_exec   ? last_cmd_q :
                    sel_acc    ? {24'h0, acc_q} :
                    sel_status ? status_word :
                    sel_wdog   ? {16'h0, presc_q, wdog_q} :
                    sel_file   ? {24'h0, apb_fval} : 32'h0;

    // Read data is captured in the setup cycle so prdata comes from a flop
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_q   <= 32'h0;
            last_cmd_q <= 32'h0;
        end
        else
        begin
            if (setup_rd)
                prdata_q <= rd_mux;
            if (exec_go)
                last_cmd_q <= pwdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            acc_q <= SRX_ACC_RST;
        else if (exec_go & ~to_file & (cmd_op != SRX_OP_SLEEP))
            acc_q <= alu_res;
        else if (acc_wr & sel_acc)
            acc_q <= pwdata[7:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            carry_q <= SRX_FLAG_RST;
            dc_q    <= SRX_FLAG_RST;
            zero_q  <= SRX_FLAG_RST;
        end
        else if (exec_go)
        begin
            if (upd_c)
                carry_q <= alu_c;
            if (upd_dc)
                dc_q <= alu_dc;
            if (upd_z)
                zero_q <= alu_res == 8'h00;
        end
        else if (acc_wr & sel_status)
        begin
            carry_q <= pwdata[SRX_ST_C];
            dc_q    <= pwdata[SRX_ST_DC];
            zero_q  <= pwdata[SRX_ST_Z];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pd_q <= SRX_PD_RST;
            to_q <= SRX_TO_RST;
        end
        else if (exec_go & (cmd_op == SRX_OP_SLEEP))
        begin
            pd_q <= 1'b0;
            to_q <= 1'b1;
        end
    end

    // watchdog and prescaler clear; the timeout itself lies outside this block
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            presc_q <= SRX_WDOG_CLR;
            wdog_q  <= SRX_WDOG_CLR;
        end
        else if (exec_go & (cmd_op == SRX_OP_SLEEP))
        begin
            presc_q <= SRX_WDOG_CLR;
            wdog_q  <= SRX_WDOG_CLR;
        end
        else
        begin
            presc_q <= presc_q + 8'h01;
            if (presc_q == 8'hff)
                wdog_q <= wdog_q + 8'h01;
        end
    end

    // Wake pin is asynchronous
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wake_s1_q <= 1'b0;
            wake_s2_q <= 1'b0;
        end
        else
        begin
            wake_s1_q <= wake_pin;
            wake_s2_q <= wake_s1_q;
        end
    end

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            SRX_RUN:
                if (exec_go & (cmd_op == SRX_OP_SLEEP))
                    state_d = SRX_ASLEEP;
            SRX_ASLEEP:
                if (wake_s2_q)
                    state_d = SRX_RUN;
            default: state_d = SRX_RUN;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_q <= SRX_RUN;
        else
            state_q <= state_d;
    end

    // Operand snapshot read only by the checks below
    logic [7:0] chk_acc_q;
    logic [7:0] chk_f_q;
    logic [7:0] chk_lit_q;
    logic       chk_c_q;
    logic       chk_dc_q;
    logic       chk_z_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            chk_acc_q <= 8'h00;
            chk_f_q   <= 8'h00;
            chk_lit_q <= 8'h00;
            chk_c_q   <= 1'b0;
            chk_dc_q  <= 1'b0;
            chk_z_q   <= 1'b0;
        end
        else if (exec_go)
        begin
            chk_acc_q <= acc_q;
            chk_f_q   <= fval;
            chk_lit_q <= cmd_lit;
            chk_c_q   <= carry_q;
            chk_dc_q  <= dc_q;
            chk_z_q   <= zero_q;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_lit_sub_result: assert property (exec_go && cmd_op == SRX_OP_LIT_SUB |=>
        acc_q == 8'(chk_lit_q - chk_acc_q))
        else $error("literal minus accumulator result wrong");
    a_rot_right_carry: assert property (exec_go && cmd_op == SRX_OP_ROT_R |=>
        carry_q == chk_f_q[0] && dc_q == chk_dc_q && zero_q == chk_z_q)
        else $error("rotate right carry or flags wrong");
    a_rot_acc_dest: assert property (exec_go && cmd_op == SRX_OP_ROT_R && !cmd_dest |=>
        acc_q == {chk_c_q, chk_f_q[7:1]})
        else $error("rotate right to accumulator wrong");
    a_file_sub_flags: assert property (exec_go && cmd_op == SRX_OP_FILE_SUB |=>
        carry_q == (chk_f_q >= chk_acc_q) && zero_q == (chk_f_q == chk_acc_q))
        else $error("file minus accumulator flags wrong");
    a_file_sub_dest: assert property (exec_go && cmd_op == SRX_OP_FILE_SUB && cmd_dest |->
        rf_we && rf_waddr == cmd_idx ##1 acc_q == chk_acc_q)
        else $error("file minus accumulator destination wrong");
    a_sleep_wdog_clear: assert property (exec_go && cmd_op == SRX_OP_SLEEP |=>
        wdog_q == 8'h00 && presc_q == 8'h00 ##1 presc_q == 8'h01)
        else $error("sleep did not clear watchdog");
    a_sleep_status_bits: assert property (exec_go && cmd_op == SRX_OP_SLEEP |=>
        !pd_q && to_q && carry_q == chk_c_q && dc_q == chk_dc_q && zero_q == chk_z_q)
        else $error("sleep status bits wrong");
    a_sleep_halts: assert property (exec_go && cmd_op == SRX_OP_SLEEP |=>
        !osc_run && !exec_go)
        else $error("sleep did not halt");
    a_swap_flags_kept: assert property (exec_go && cmd_op == SRX_OP_SWAP |=>
        carry_q == chk_c_q && dc_q == chk_dc_q && zero_q == chk_z_q)
        else $error("nibble exchange changed a flag");
    a_swap_dest_sel: assert property (exec_go && cmd_op == SRX_OP_SWAP && !cmd_dest |=>
        acc_q == {chk_f_q[3:0], chk_f_q[7:4]})
        else $error("nibble exchange to accumulator wrong");
    a_xor_lit_result: assert property (exec_go && cmd_op == SRX_OP_XOR_LIT |=>
        acc_q == (chk_acc_q ^ chk_lit_q) && carry_q == chk_c_q && dc_q == chk_dc_q)
        else $error("xor literal wrong");
    a_xor_file_dest: assert property (exec_go && cmd_op == SRX_OP_XOR_FILE && cmd_dest |->
        rf_we ##1 acc_q == chk_acc_q && carry_q == chk_c_q)
        else $error("xor file destination wrong");
    a_zero_flag_set: assert property (exec_go && upd_z |=>
        zero_q == ($past(alu_res) == 8'h00))
        else $error("zero flag wrong");
    a_nibble_borrow: assert property (exec_go && cmd_op == SRX_OP_LIT_SUB |=>
        dc_q == (chk_lit_q[3:0] >= chk_acc_q[3:0]) && carry_q == (chk_lit_q >= chk_acc_q))
        else $error("borrow flags wrong");

    c_sleep_entry: cover property (exec_go && cmd_op == SRX_OP_SLEEP);
    c_wake_up: cover property (asleep ##1 !asleep);
    c_sub_borrow: cover property (exec_go && cmd_op == SRX_OP_FILE_SUB && !alu_c);
    c_rot_to_file: cover property (exec_go && cmd_op == SRX_OP_ROT_R && cmd_dest);
endmodule

// [design/srx_regfile.sv]
// 128-entry by 8-bit file register store, one write port and two read ports
`timescale 1ns/1ps
module srx_regfile
(
    // Clock
    input  wire logic       clk,
    // Write port
    input  wire logic       we,
    input  wire logic [6:0] waddr,
    input  wire logic [7:0] wdata,
    // Read ports
    input  wire logic [6:0] raddr_a,
    output logic      [7:0] rdata_a,
    input  wire logic [6:0] raddr_b,
    output logic      [7:0] rdata_b
);
    logic [7:0] mem [0:127];

    // Contents are data, not control, so no reset is spent on them
    always_ff @(posedge clk)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
    end

    assign rdata_a = mem[raddr_a];
    assign rdata_b = mem[raddr_b];
endmodule

// [pkg/srx_pkg.sv]
// Shared constants and types for the subtract, rotate, swap, xor and sleep datapath
package srx_pkg;
    // Byte offsets on the APB
    localparam logic [11:0] SRX_EXEC_OFS   = 12'h000;
    localparam logic [11:0] SRX_ACC_OFS    = 12'h004;
    localparam logic [11:0] SRX_STATUS_OFS = 12'h008;
    localparam logic [11:0] SRX_WDOG_OFS   = 12'h00c;
    localparam logic [11:0] SRX_FILE_BASE  = 12'h200;
    localparam logic [2:0]  SRX_FILE_SEL   = 3'h1;

    // Command word fields
    localparam int SRX_EXEC_OP_LSB  = 0;
    localparam int SRX_EXEC_DEST    = 3;
    localparam int SRX_EXEC_IDX_LSB = 4;
    localparam int SRX_EXEC_LIT_LSB = 16;

    // Status word fields
    localparam int SRX_ST_C     = 0;
    localparam int SRX_ST_DC    = 1;
    localparam int SRX_ST_Z     = 2;
    localparam int SRX_ST_PD    = 3;
    localparam int SRX_ST_TO    = 4;
    localparam int SRX_ST_SLEEP = 5;

    // Watchdog word fields
    localparam int SRX_WD_CNT_LSB = 0;
    localparam int SRX_WD_PRE_LSB = 8;

    // Reset values
    localparam logic [7:0] SRX_ACC_RST  = 8'h00;
    localparam logic       SRX_FLAG_RST = 1'b0;
    localparam logic       SRX_PD_RST   = 1'b1;
    localparam logic       SRX_TO_RST   = 1'b1;
    localparam logic [7:0] SRX_WDOG_CLR = 8'h00;

    // Operation codes
    localparam logic [2:0] SRX_OP_NONE     = 3'h0;
    localparam logic [2:0] SRX_OP_LIT_SUB  = 3'h1;
    localparam logic [2:0] SRX_OP_FILE_SUB = 3'h2;
    localparam logic [2:0] SRX_OP_ROT_R    = 3'h3;
    localparam logic [2:0] SRX_OP_SWAP     = 3'h4;
    localparam logic [2:0] SRX_OP_XOR_LIT  = 3'h5;
    localparam logic [2:0] SRX_OP_XOR_FILE = 3'h6;
    localparam logic [2:0] SRX_OP_SLEEP    = 3'h7;

    typedef enum logic {SRX_RUN, SRX_ASLEEP} srx_state_type;
endpackage

// [verification/tb_srx_exec.sv]
// Self-checking bench for the subtract, rotate, swap, xor and sleep datapath
`timescale 1ns/1ps
module tb_srx_exec
    import srx_pkg::*;
;
    // Clock and reset
    logic        pclk;
    logic        presetn;
    // APB
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    // Wake and clock control
    logic        wake_pin;
    logic        osc_run;
    // Bench state and reference model
    int          n_fail;
    int          checked;
    int          cycles;
    logic [31:0] rd;
    logic        err;
    logic [7:0]  acc_m;
    logic [7:0]  fmem [0:127];
    logic        c_m;
    logic        dc_m;
    logic        z_m;
    logic        pd_m;
    logic        to_m;
    logic        asleep_m;

    srx_exec dut
    (
        .pclk    (pclk),
        .presetn (presetn),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr),
        .wake_pin(wake_pin),
        .osc_run (osc_run)
    );

    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Runaway guard: the whole sequence needs well under a thousand cycles
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_fail++;
            $display("unexpected at %0t: run did not finish", $time);
            report_and_stop();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // One APB transfer; request held until pready is seen at a rising edge
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
        begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr_reg(input logic [11:0] a, input logic [31:0] d, input logic exp_err);
        xfer(1'b1, a, d);
        check({31'h0, err}, {31'h0, exp_err}, "write error response");
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string what);
        xfer(1'b0, a, 32'h0);
        check(rd, exp, what);
        check({31'h0, err}, 32'h0, "read error response");
    endtask

    function automatic logic [11:0] faddr(input logic [6:0] i);
        return SRX_FILE_BASE + {3'h0, i, 2'b00};
    endfunction

    task automatic chk_state(input logic [6:0] i);
        rd_chk(SRX_ACC_OFS, {24'h0, acc_m}, "accumulator");
        rd_chk(SRX_STATUS_OFS, {26'h0, asleep_m, to_m, pd_m, z_m, dc_m, c_m}, "status");
        rd_chk(faddr(i), {24'h0, fmem[i]}, "file register");
    endtask

    task automatic set_acc(input logic [7:0] v);
        wr_reg(SRX_ACC_OFS, {24'h0, v}, 1'b0);
        acc_m = v;
    endtask

    task automatic set_file(input logic [6:0] i, input logic [7:0] v);
        wr_reg(faddr(i), {24'h0, v}, 1'b0);
        fmem[i] = v;
    endtask

    task automatic set_flags(input logic [2:0] v);
        wr_reg(SRX_STATUS_OFS, {29'h0, v}, 1'b0);
        {z_m, dc_m, c_m} = v;
    endtask

    // Reference result, then the command, then a full read-back
    task automatic run_op(input logic [2:0] op, input logic dest, input logic [6:0] i,
                          input logic [7:0] lit);
        logic [7:0] f;
        logic [7:0] src;
        logic [7:0] res;
        f = fmem[i];
        src = (op == SRX_OP_LIT_SUB) ? lit : f;
        res = 8'h00;
        case (op)
            SRX_OP_LIT_SUB, SRX_OP_FILE_SUB:
            begin
                res = src - acc_m;
                c_m = (src >= acc_m);
                dc_m = (src[3:0] >= acc_m[3:0]);
            end
            // old carry in at the top
            SRX_OP_ROT_R:
            begin
                res = {c_m, f[7:1]};
                c_m = f[0];
            end
            SRX_OP_SWAP:     res = {f[3:0], f[7:4]};
            SRX_OP_XOR_LIT:  res = acc_m ^ lit;
            SRX_OP_XOR_FILE: res = acc_m ^ f;
            default:         res = 8'h00;
        endcase
        if (op != SRX_OP_ROT_R && op != SRX_OP_SWAP)
            z_m = (res == 8'h00);
        // target select, literal forms always to the accumulator
        if (op == SRX_OP_LIT_SUB || op == SRX_OP_XOR_LIT || !dest)
            acc_m = res;
        else
            fmem[i] = res;
        wr_reg(SRX_EXEC_OFS, {8'h0, lit, 5'h0, i, dest, op}, 1'b0);
        chk_state(i);
    endtask

    task automatic end_test(input string name);
        $display("test %s done, mismatches so far %0d", name, n_fail);
    endtask

    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        wake_pin = 1'b0;
        n_fail = 0;
        checked = 0;
        cycles = 0;
        {acc_m, c_m, dc_m, z_m, pd_m, to_m, asleep_m} = {8'h00, 6'b000110};
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(SRX_ACC_OFS, 32'h0, "accumulator after reset");
        rd_chk(SRX_STATUS_OFS, 32'h18, "status after reset");
        end_test("reset");

        // File registers have no reset, so give every one read back a known value
        set_file(7'd0, 8'h44);
        set_file(7'd2, 8'h99);
        set_file(7'd5, 8'h66);
        set_acc(8'h05);
        run_op(SRX_OP_LIT_SUB, 1'b0, 7'd0, 8'h03);
        set_acc(8'h01);
        run_op(SRX_OP_LIT_SUB, 1'b1, 7'd5, 8'h10);
        set_acc(8'h3c);
        run_op(SRX_OP_LIT_SUB, 1'b0, 7'd0, 8'h3c);
        set_file(7'd127, 8'h80);
        set_acc(8'h01);
        run_op(SRX_OP_FILE_SUB, 1'b1, 7'd127, 8'h00);
        set_file(7'd0, 8'h12);
        set_acc(8'hff);
        run_op(SRX_OP_FILE_SUB, 1'b0, 7'd0, 8'h00);
        set_acc(8'h13);
        run_op(SRX_OP_FILE_SUB, 1'b0, 7'd0, 8'h00);
        end_test("subtract");

        set_flags(3'b111);
        set_file(7'd9, 8'h81);
        run_op(SRX_OP_ROT_R, 1'b0, 7'd9, 8'h00);
        run_op(SRX_OP_ROT_R, 1'b1, 7'd9, 8'h00);
        set_flags(3'b000);
        run_op(SRX_OP_ROT_R, 1'b1, 7'd9, 8'h00);
        end_test("rotate");

        set_flags(3'b101);
        set_file(7'd33, 8'ha5);
        run_op(SRX_OP_SWAP, 1'b0, 7'd33, 8'h00);
        run_op(SRX_OP_SWAP, 1'b1, 7'd33, 8'h00);
        end_test("swap");

        set_flags(3'b011);
        set_acc(8'h5a);
        run_op(SRX_OP_XOR_LIT, 1'b1, 7'd2, 8'h5a);
        run_op(SRX_OP_XOR_LIT, 1'b0, 7'd2, 8'hff);
        set_file(7'd64, 8'h0f);
        run_op(SRX_OP_XOR_FILE, 1'b0, 7'd64, 8'h00);
        run_op(SRX_OP_XOR_FILE, 1'b1, 7'd64, 8'h00);
        end_test("xor");

        wr_reg(SRX_EXEC_OFS, 32'h0000_0018, 1'b1);
        chk_state(7'd0);
        xfer(1'b0, 12'h100, 32'h0);
        check(rd, 32'h0, "unmapped read data");
        check({31'h0, err}, 32'h1, "unmapped read error");
        end_test("refusal");

        // The watchdog must have counted past one prescaler wrap by now
        repeat (300) @(posedge pclk);
        xfer(1'b0, SRX_WDOG_OFS, 32'h0);
        check({31'h0, rd[7:0] != 8'h00}, 32'h1, "watchdog running");
        wr_reg(SRX_EXEC_OFS, {29'h0, SRX_OP_SLEEP}, 1'b0);
        {pd_m, to_m, asleep_m} = 3'b011;
        xfer(1'b0, SRX_WDOG_OFS, 32'h0);
        check({24'h0, rd[7:0]}, {24'h0, SRX_WDOG_CLR}, "watchdog after sleep");
        check({31'h0, rd[15:8] < 8'h08}, 32'h1, "prescaler after sleep");
        check({31'h0, osc_run}, 32'h0, "oscillator halted");
        chk_state(7'd64);
        wr_reg(SRX_EXEC_OFS, {8'h0, 8'h77, 13'h0, SRX_OP_XOR_LIT}, 1'b1);
        chk_state(7'd64);
        wake_pin <= 1'b1;
        repeat (4) @(posedge pclk);
        check({31'h0, osc_run}, 32'h1, "oscillator after wake");
        wake_pin <= 1'b0;
        asleep_m = 1'b0;
        run_op(SRX_OP_XOR_LIT, 1'b0, 7'd64, 8'h77);
        end_test("sleep");
        report_and_stop();
    end
endmodule
